// >>> verilog/dcw_defs.svh
/*
 Control word decoder constants: bit positions, reset values, timing counts.
 Assumes a 40 MHz clk and a 16-bit control word sampled once per cyclic update.
*/
`ifndef DCW_DEFS_SVH
`define DCW_DEFS_SVH

`define DCW_B_MAN_UP 0
`define DCW_B_MAN_DN 1
`define DCW_B_XFER 2
`define DCW_B_JOG_CONT 3
`define DCW_B_REL 4
`define DCW_B_KEY_JOG 5
`define DCW_B_NO_LOOP 6
`define DCW_B_SW_LOOP 7
`define DCW_B_JOG_UP 8
`define DCW_B_JOG_DN 9
`define DCW_B_ACK 14
`define DCW_RSV_MASK 16'hBC00
`define DCW_CW_RESET 16'h0000
`define DCW_CLK_HZ 40000000
`define DCW_LONG_PRESS_MS 500
`define DCW_LONG_PRESS_CYC (`DCW_LONG_PRESS_MS * (`DCW_CLK_HZ / 1000))

`endif

// >>> verilog/dcw_pkg.sv
/*
 Types shared by the control word decoder files.
 Assumes nothing beyond a SystemVerilog elaborator.
*/
`default_nettype none
package dcw_pkg;
	typedef logic [15:0] dcw_word_t;
	typedef enum logic [1:0] {dcw_idle, dcw_pos, dcw_man, dcw_loop} dcw_run_t;
endpackage
`default_nettype wire

// >>> verilog/dcw_jog_timer.sv
/*
 Jog hold timer: one step on press, continuous motion after a long hold.
 Assumes hold is a clean synchronous level.
*/
`default_nettype none
module dcw_jog_timer #(
	parameter int unsigned HOLD_CYC = 20000000
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic hold,
	input wire logic cont_en,
	output logic step,
	output logic cont
);
	localparam int unsigned CW = $clog2(HOLD_CYC + 1);
	logic hold_q;
	logic [CW-1:0] cnt;
	wire held_long = (cnt == CW'(HOLD_CYC));

	generate
		if (HOLD_CYC < 1) begin : g_chk
			$error("HOLD_CYC must be at least one cycle");
		end
	endgenerate

	always_ff @(posedge clk) begin
		if (!nrst) begin
			hold_q <= 1'b0;
			cnt <= '0;
			step <= 1'b0;
			cont <= 1'b0;
		end else begin
			hold_q <= hold;
			// Saturates so a very long hold never wraps
			cnt <= !hold ? '0 : (held_long ? cnt : cnt + 1'b1);
			step <= hold & ~hold_q;
			cont <= hold & cont_en & held_long;
		end
	end
endmodule
`default_nettype wire

// >>> verilog/dcw_fault_latch.sv
/*
 Failure display with optional latch, driven by the acknowledgement level.
 Assumes live_fail is high while the monitored input is in failure.
*/
`default_nettype none
module dcw_fault_latch (
	input wire logic clk,
	input wire logic nrst,
	input wire logic live_fail,
	input wire logic ack,
	input wire logic arm,
	input wire logic unlatch,
	output logic shown_fail
);
	logic latched;
	wire catch_fail = ack & arm & live_fail;

	always_ff @(posedge clk) begin
		if (!nrst) begin
			latched <= 1'b0;
			shown_fail <= 1'b0;
		end else begin
			latched <= catch_fail | (latched & ~unlatch);
			shown_fail <= live_fail | (ack & (latched | catch_fail));
		end
	end
endmodule
`default_nettype wire

// >>> verilog/dcw_decoder.sv
/*
 Drive control word decoder: target takeover, release gate, manual and jog
 runs, loop suppression, switch-on loop, acknowledgement and status flags.
 Assumes cmd_strobe pulses once per cyclic process data update with the word
 and target stable, and that motion logic reports completion on run_done.
*/
`include "dcw_defs.svh"
`default_nettype none
module dcw_decoder #(
	parameter int unsigned TGT_W = 32,
	parameter int unsigned LONG_PRESS_CYC = `DCW_LONG_PRESS_CYC
) (
	input wire logic clk,
	input wire logic nrst,
	input wire dcw_pkg::dcw_word_t cmd_word,
	input wire logic cmd_strobe,
	input wire logic [TGT_W-1:0] target_in,
	input wire logic bus_active,
	input wire logic key_fwd,
	input wire logic key_rev,
	input wire logic safe_torque_off_ok,
	input wire logic volt_fail,
	input wire logic drive_moving,
	input wire logic run_done,
	input wire logic evt_block,
	input wire logic evt_disp,
	input wire logic evt_target,
	output logic [TGT_W-1:0] target_valid,
	output logic pos_start,
	output logic man_fwd,
	output logic man_rev,
	output logic jog_step_fwd,
	output logic jog_step_rev,
	output logic jog_cont_fwd,
	output logic jog_cont_rev,
	output logic direct_approach,
	output logic loop_active,
	output logic run_abort,
	output logic cw_reserved_err,
	output logic stat_sto_ok,
	output logic stat_aborted,
	output logic stat_block,
	output logic stat_disp,
	output logic stat_target_err,
	output logic stat_volt_fail
);
	import dcw_pkg::*;

	generate
		if (TGT_W < 1 || TGT_W > 64) begin : g_chk_w
			$error("TGT_W must lie between 1 and 64");
		end
		if (LONG_PRESS_CYC < 1) begin : g_chk_t
			$error("LONG_PRESS_CYC must be at least one cycle");
		end
	endgenerate

	function automatic logic bad_combo(input dcw_word_t w);
		logic man;
		logic jog;
		man = w[`DCW_B_MAN_UP] | w[`DCW_B_MAN_DN];
		jog = w[`DCW_B_JOG_UP] | w[`DCW_B_JOG_DN];
		bad_combo = (w[`DCW_B_MAN_UP] & w[`DCW_B_MAN_DN])
			| (w[`DCW_B_JOG_UP] & w[`DCW_B_JOG_DN])
			| (jog & w[`DCW_B_KEY_JOG])
			| (man & jog)
			| ((man | jog) & w[`DCW_B_SW_LOOP]);
	endfunction

	dcw_word_t cw;
	dcw_word_t loop_word;
	dcw_run_t st;
	dcw_run_t next_st;
	logic man_up;
	logic sto_fail_shown;

	wire take = cmd_strobe;
	wire dcw_word_t w = cmd_word;

	wire w_rel = w[`DCW_B_REL];
	wire w_man = w[`DCW_B_MAN_UP] | w[`DCW_B_MAN_DN];
	wire w_jog = w[`DCW_B_JOG_UP] | w[`DCW_B_JOG_DN];
	wire w_bad = bad_combo(w);
	wire rise_xfer = w[`DCW_B_XFER] & ~cw[`DCW_B_XFER];
	wire rise_rel = w_rel & ~cw[`DCW_B_REL];
	wire rise_loop = w[`DCW_B_SW_LOOP] & ~cw[`DCW_B_SW_LOOP];
	wire rise_man = (w[`DCW_B_MAN_UP] & ~cw[`DCW_B_MAN_UP])
		| (w[`DCW_B_MAN_DN] & ~cw[`DCW_B_MAN_DN]);
	wire rise_jog = (w[`DCW_B_JOG_UP] & ~cw[`DCW_B_JOG_UP])
		| (w[`DCW_B_JOG_DN] & ~cw[`DCW_B_JOG_DN]);

	wire run_ok = take & w_rel & ~w_bad;
	wire loop_trig = run_ok & rise_loop & ~w_man & ~w_jog;
	wire man_trig = run_ok & w_man;
	wire pos_trig = run_ok & ~w_man & ~w_jog & ~w[`DCW_B_SW_LOOP] & (rise_xfer | rise_rel);
	wire jog_trig = run_ok & w_jog & rise_jog;

	wire loop_change = take & (w != loop_word);
	wire rel_drop = take & ~w_rel;
	wire combo_drop = take & w_bad;

	wire idle = (st == dcw_idle);
	wire start_run = idle & (loop_trig | man_trig | pos_trig);
	wire new_run = start_run | (idle & jog_trig) | ((st == dcw_pos) & pos_trig);
	wire abort_run = ((st == dcw_pos) | (st == dcw_man)) & (rel_drop | combo_drop);
	wire abort_loop = (st == dcw_loop) & loop_change;
	wire abort_evt = abort_run | abort_loop;

	wire ack_rise = take & w[`DCW_B_ACK] & ~cw[`DCW_B_ACK];
	wire ack_fall = take & ~w[`DCW_B_ACK] & cw[`DCW_B_ACK];

	wire cw_bad = bad_combo(cw);
	wire key_ok = ~bus_active | (cw[`DCW_B_KEY_JOG] & ~cw[`DCW_B_REL]);
	wire bus_jog_fwd = cw[`DCW_B_REL] & cw[`DCW_B_JOG_UP] & ~cw_bad;
	wire bus_jog_rev = cw[`DCW_B_REL] & cw[`DCW_B_JOG_DN] & ~cw[`DCW_B_KEY_JOG] & ~cw_bad;
	// Jog only from the idle run state so it cannot fight a run
	wire hold_fwd = idle & ((key_ok & key_fwd) | bus_jog_fwd);
	wire hold_rev = idle & ((key_ok & key_rev) | bus_jog_rev);
	wire moving = drive_moving | ~idle | jog_cont_fwd | jog_cont_rev;
	// Word in force after this edge, so flags follow one cycle after the strobe
	wire dcw_word_t cw_now = take ? w : cw;

	always_comb begin
		next_st = st;
		case (st)
			dcw_idle: begin
				if (loop_trig) begin
					next_st = dcw_loop;
				end else if (man_trig) begin
					next_st = dcw_man;
				end else if (pos_trig) begin
					next_st = dcw_pos;
				end
			end
			dcw_pos: begin
				if (abort_run | run_done) begin
					next_st = dcw_idle;
				end
			end
			dcw_man: begin
				// Letting go of the run bit is a normal stop, not an abort
				if (abort_run | (take & ~w_man)) begin
					next_st = dcw_idle;
				end
			end
			dcw_loop: begin
				if (abort_loop | run_done) begin
					next_st = dcw_idle;
				end
			end
			default: begin
				next_st = dcw_idle;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			cw <= `DCW_CW_RESET;
			loop_word <= `DCW_CW_RESET;
			st <= dcw_idle;
			man_up <= 1'b0;
		end else begin
			st <= next_st;
			if (take) begin
				cw <= w;
			end
			if (loop_trig & idle) begin
				loop_word <= w;
			end
			if (man_trig & idle) begin
				man_up <= w[`DCW_B_MAN_UP];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			target_valid <= '0;
		end else if (take & w[`DCW_B_XFER]) begin
			target_valid <= target_in;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			pos_start <= 1'b0;
			run_abort <= 1'b0;
			direct_approach <= 1'b0;
			cw_reserved_err <= 1'b0;
		end else begin
			pos_start <= pos_trig & ((st == dcw_idle) | (st == dcw_pos));
			run_abort <= abort_evt;
			direct_approach <= cw_now[`DCW_B_NO_LOOP];
			cw_reserved_err <= |(cw_now & `DCW_RSV_MASK);
		end
	end

	assign man_fwd = (st == dcw_man) & man_up;
	assign man_rev = (st == dcw_man) & ~man_up;
	// loop motion owned by motion logic
	assign loop_active = (st == dcw_loop);

	always_ff @(posedge clk) begin
		if (!nrst) begin
			stat_aborted <= 1'b0;
			stat_block <= 1'b0;
			stat_disp <= 1'b0;
			stat_target_err <= 1'b0;
		end else begin
			stat_aborted <= abort_evt | (stat_aborted & ~(new_run | ack_rise));
			stat_block <= evt_block | (stat_block & ~(new_run | ack_rise));
			stat_disp <= evt_disp | (stat_disp & ~(new_run | ack_rise));
			stat_target_err <= evt_target | (stat_target_err & ~(new_run | ack_rise));
		end
	end

	// Both jog directions share one timer design
	dcw_jog_timer #(
		.HOLD_CYC(LONG_PRESS_CYC)
	) u_jog_fwd (
		.clk(clk),
		.nrst(nrst),
		.hold(hold_fwd),
		.cont_en(cw[`DCW_B_JOG_CONT]),
		.step(jog_step_fwd),
		.cont(jog_cont_fwd)
	);

	dcw_jog_timer #(
		.HOLD_CYC(LONG_PRESS_CYC)
	) u_jog_rev (
		.clk(clk),
		.nrst(nrst),
		.hold(hold_rev),
		.cont_en(cw[`DCW_B_JOG_CONT]),
		.step(jog_step_rev),
		.cont(jog_cont_rev)
	);

	dcw_fault_latch u_sto (
		.clk(clk),
		.nrst(nrst),
		.live_fail(~safe_torque_off_ok),
		.ack(cw[`DCW_B_ACK]),
		.arm(moving | new_run),
		.unlatch(new_run | ack_fall),
		.shown_fail(sto_fail_shown)
	);

	dcw_fault_latch u_volt (
		.clk(clk),
		.nrst(nrst),
		.live_fail(volt_fail),
		.ack(cw[`DCW_B_ACK]),
		.arm(moving | new_run),
		.unlatch(new_run | ack_fall),
		.shown_fail(stat_volt_fail)
	);

	assign stat_sto_ok = ~sto_fail_shown;
endmodule
`default_nettype wire

// >>> verification/dcw_scanner.sv
/*
 Scanner model: one control word and target per cyclic update.
 Assumes the bench calls send and the decoder samples on the strobe.
*/
`default_nettype none
module dcw_scanner (
	input wire logic clk,
	output dcw_pkg::dcw_word_t cmd_word,
	output logic cmd_strobe,
	output logic [31:0] target_in
);
	timeunit 1ns;
	timeprecision 100ps;
	import dcw_pkg::*;
	initial begin
		cmd_word = 16'h0000;
		cmd_strobe = 1'b0;
		target_in = 32'h0;
	end
	task automatic send(input dcw_word_t w, input logic [31:0] t);
		@(negedge clk);
		cmd_word = w & 16'h43FF;
		target_in = t;
		cmd_strobe = 1'b1;
		@(negedge clk);
		cmd_strobe = 1'b0;
		// Invalid outside the strobe, so no stale value passes
		cmd_word = ~cmd_word;
		target_in = ~target_in;
	endtask
endmodule
`default_nettype wire

// >>> verification/dcw_decoder_assertions.sv
/*
 Port checker for the control word decoder.
 Assumes it is bound to the decoder and sees its ports only.
*/
`default_nettype none
module dcw_decoder_assertions #(
	parameter int unsigned TGT_W = 32
) (
	input wire logic clk,
	input wire logic nrst,
	input wire dcw_pkg::dcw_word_t cmd_word,
	input wire logic cmd_strobe,
	input wire logic [TGT_W-1:0] target_in,
	input wire logic evt_block,
	input wire logic safe_torque_off_ok,
	input wire logic volt_fail,
	input wire logic [TGT_W-1:0] target_valid,
	input wire logic pos_start,
	input wire logic man_fwd,
	input wire logic direct_approach,
	input wire logic loop_active,
	input wire logic stat_sto_ok,
	input wire logic stat_block,
	input wire logic stat_volt_fail
);
	import dcw_pkg::*;
	logic last_ack;
	dcw_word_t last_word;
	always_ff @(posedge clk) begin
		if (!nrst) begin
			last_ack <= 1'b0;
			last_word <= 16'h0000;
		end else if (cmd_strobe) begin
			last_ack <= cmd_word[14];
			last_word <= cmd_word;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	chk_pos_release: assert property (pos_start |-> $past(cmd_strobe && cmd_word[4]))
		else $error("pos_start without release");
	chk_man_drop: assert property (cmd_strobe && !cmd_word[4] |=> !man_fwd)
		else $error("manual run kept without release");
	chk_target_take: assert property (cmd_strobe && cmd_word[2] && !loop_active
		&& (cmd_word & 16'h0383) == 16'h0000 |=> target_valid == $past(target_in))
		else $error("target not taken");
	chk_target_keep: assert property (!(cmd_strobe && cmd_word[2]) |=> $stable(target_valid))
		else $error("target changed without transfer");
	chk_direct_bit: assert property (cmd_strobe && !loop_active
		|=> direct_approach == $past(cmd_word[6]))
		else $error("direct approach mismatch");
	chk_loop_exit: assert property (loop_active && cmd_strobe && cmd_word != last_word
		|=> !loop_active)
		else $error("loop not ended by changed word");
	chk_ack_clear: assert property (cmd_strobe && cmd_word[14] && !last_ack
		&& !loop_active && !evt_block |=> !stat_block)
		else $error("ack rise left block status");
	chk_sto_live: assert property ((!last_ack && $stable(safe_torque_off_ok))[*4]
		|-> stat_sto_ok == safe_torque_off_ok)
		else $error("torque-off status not live");
	chk_volt_live: assert property ((!last_ack && $stable(volt_fail))[*4]
		|-> stat_volt_fail == volt_fail)
		else $error("voltage status not live");
endmodule
bind dcw_decoder dcw_decoder_assertions #(.TGT_W(TGT_W)) i_chk (
	.clk, .nrst, .cmd_word, .cmd_strobe, .target_in, .evt_block, .safe_torque_off_ok,
	.volt_fail, .target_valid, .pos_start, .man_fwd, .direct_approach, .loop_active,
	.stat_sto_ok, .stat_block, .stat_volt_fail
);
`default_nettype wire

// >>> verification/drive_control_word_decoder_tb.sv
/*
 Self-checking bench for the control word decoder.
 Assumes the scanner model and checker are compiled first.
*/
`default_nettype none
module drive_control_word_decoder_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import dcw_pkg::*;
	localparam int LP = 6;
	logic clk = 1'b0, nrst = 1'b0, bus_active = 1'b0, key_fwd = 1'b0, key_rev = 1'b0;
	logic sto_ok = 1'b1, volt = 1'b0, blk = 1'b0, zero = 1'b0;
	int failures = 0, tests_run = 0, n_pos = 0, n_jog = 0, n_ab = 0, n_jr = 0;
	logic man_rev, jog_step_rev, direct_approach;
	dcw_word_t cmd_word;
	logic cmd_strobe, pos_start, man_fwd, jog_step_fwd, jog_cont_fwd, loop_active, run_abort;
	logic stat_sto_ok, stat_aborted, stat_block, stat_volt_fail;
	logic [31:0] target_in, target_valid;
	always #12.5 clk = ~clk;
	dcw_scanner i_scn (.clk, .cmd_word, .cmd_strobe, .target_in);
	dcw_decoder #(.LONG_PRESS_CYC(LP)) i_dut (
		.clk, .nrst, .cmd_word, .cmd_strobe, .target_in, .bus_active, .key_fwd, .key_rev,
		.safe_torque_off_ok(sto_ok), .volt_fail(volt), .drive_moving(zero), .run_done(zero),
		.evt_block(blk), .evt_disp(zero), .evt_target(zero), .target_valid, .pos_start,
		.man_fwd, .man_rev, .jog_step_fwd, .jog_step_rev, .jog_cont_fwd, .jog_cont_rev(),
		.direct_approach, .loop_active, .run_abort, .cw_reserved_err(), .stat_sto_ok,
		.stat_aborted, .stat_block, .stat_disp(), .stat_target_err(), .stat_volt_fail
	);
	always @(posedge clk) begin
		if (pos_start === 1'b1) n_pos <= n_pos + 1;
		if (jog_step_fwd === 1'b1) n_jog <= n_jog + 1;
		if (run_abort === 1'b1) n_ab <= n_ab + 1;
		if (jog_step_rev === 1'b1) n_jr <= n_jr + 1;
	end
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] %s exp=%h got=%h", nm, e, g);
		end
	endtask
	task automatic snd(input dcw_word_t w, input logic [31:0] t);
		i_scn.send(w, t);
		repeat (2) @(negedge clk);
	endtask
	task automatic t_pos;
		int p;
		p = n_pos;
		snd(16'h0014, 32'hA5A50001);
		chk("target", 32'hA5A50001, target_valid);
		chk("pos_start", p + 1, n_pos);
		snd(16'h0010, 32'h00000BAD);
		chk("target kept", 32'hA5A50001, target_valid);
		p = n_ab;
		snd(16'h0000, 32'h0);
		chk("abort", p + 1, n_ab);
		chk("aborted", 32'h1, stat_aborted);
		snd(16'h0011, 32'h0);
		chk("man up", 32'h1, man_fwd);
		snd(16'h0001, 32'h0);
		chk("man no rel", 32'h0, man_fwd);
		snd(16'h0000, 32'h0);
		$display("pos test done");
	endtask
	task automatic t_loop;
		snd(16'h0090, 32'h0);
		chk("loop on", 32'h1, loop_active);
		snd(16'h0090, 32'h0);
		chk("loop kept", 32'h1, loop_active);
		snd(16'h0000, 32'h0);
		chk("loop off", 32'h0, loop_active);
		chk("loop aborted", 32'h1, stat_aborted);
		$display("loop test done");
	endtask
	task automatic t_jog;
		int j;
		bus_active = 1'b1;
		j = n_jog;
		snd(16'h0110, 32'h0);
		chk("bus jog", j + 1, n_jog);
		repeat (LP + 4) @(negedge clk);
		chk("no cont", 32'h0, jog_cont_fwd);
		snd(16'h0118, 32'h0);
		repeat (LP + 4) @(negedge clk);
		chk("cont", 32'h1, jog_cont_fwd);
		snd(16'h0000, 32'h0);
		j = n_jog;
		snd(16'h0030, 32'h0);
		key_fwd = 1'b1;
		repeat (3) @(negedge clk);
		chk("key blocked", j, n_jog);
		snd(16'h0020, 32'h0);
		chk("key jog", j + 1, n_jog);
		key_fwd = 1'b0;
		bus_active = 1'b0;
		snd(16'h0000, 32'h0);
		$display("jog test done");
	endtask
	task automatic t_ack;
		blk = 1'b1;
		@(negedge clk);
		blk = 1'b0;
		@(negedge clk);
		snd(16'h4000, 32'h0);
		chk("ack blk", 32'h0, stat_block);
		chk("ack abort", 32'h0, stat_aborted);
		sto_ok = 1'b0;
		snd(16'h4011, 32'h0);
		sto_ok = 1'b1;
		repeat (4) @(negedge clk);
		chk("sto latch", 32'h0, stat_sto_ok);
		snd(16'h0000, 32'h0);
		repeat (4) @(negedge clk);
		chk("sto free", 32'h1, stat_sto_ok);
		volt = 1'b1;
		repeat (5) @(negedge clk);
		chk("volt live", 32'h1, stat_volt_fail);
		volt = 1'b0;
		$display("ack test done");
	endtask
	task automatic t_rev;
		int j;
		j = n_jr;
		snd(16'h0210, 32'h0);
		chk("rev jog", j + 1, n_jr);
		snd(16'h0000, 32'h0);
		j = n_jr;
		snd(16'h0230, 32'h0);
		chk("rev jog key bit", j, n_jr);
		snd(16'h0012, 32'h0);
		chk("man down", 32'h1, man_rev);
		snd(16'h0013, 32'h0);
		chk("combo stop", 32'h0, man_rev);
		chk("combo aborted", 32'h1, stat_aborted);
		snd(16'h0000, 32'h0);
		snd(16'h0050, 32'h0);
		chk("direct", 32'h1, direct_approach);
		snd(16'h0000, 32'h0);
		chk("loop again", 32'h0, direct_approach);
		$display("rev test done");
	endtask
	task automatic test_done;
		$display("checks %0d failures %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	initial begin
		repeat (20) @(negedge clk);
		nrst = 1'b1;
		t_pos();
		t_loop();
		t_jog();
		t_ack();
		t_rev();
		test_done();
	end
endmodule
`default_nettype wire
